// [clock_source_pkg.sv]
`default_nettype none
package clock_source_pkg;

  // ----------------------------------------------------------------
  // Parameter register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_RATE    = 16'h4E20;
  localparam logic [15:0] IDX_CLKOUT  = 16'h4E8E;
  localparam logic [15:0] IDX_OUTFREQ = 16'h4E8F;
  localparam logic [15:0] IDX_REFCLK  = 16'h4EB0;
  localparam logic [15:0] IDX_MODE    = 16'h4EE8;
  localparam logic [15:0] IDX_AVAIL   = 16'h4EE9;
  localparam logic [15:0] IDX_SYNC    = 16'h4EF0;

  // ----------------------------------------------------------------
  // Clock source codes and PLL reference selects
  // ----------------------------------------------------------------
  localparam logic [31:0] SRC_PRIMARY   = 32'h0000_0001;
  localparam logic [31:0] SRC_SECONDARY = 32'h0000_0004;
  localparam logic [31:0] SRC_EXTERNAL  = 32'h0000_0020;
  localparam logic [1:0]  SEL_PRIMARY   = 2'h0;
  localparam logic [1:0]  SEL_SECONDARY = 2'h1;
  localparam logic [1:0]  SEL_EXTERNAL  = 2'h2;

  // Rate grid of each source as a power of two in hertz
  localparam logic [5:0]  SHIFT_PRIMARY   = 6'h00;
  localparam logic [5:0]  SHIFT_SECONDARY = 6'h04;
  localparam logic [5:0]  SHIFT_EXTERNAL  = 6'h0A;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] RATE_RESET = 64'h0000_0000_0098_9680;
  localparam logic [63:0] REF_RESET  = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Lock timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned LOCK_MAX_MS     = 200;
  localparam int unsigned LOCK_MAX_CYCLES = LOCK_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_CNT_W      = 22;

  typedef enum logic [0:0] {
    LK_IDLE = 1'b0,
    LK_WAIT = 1'b1
  } lock_state_t;

  // Source code is one the board can use
  function automatic logic src_supported(input logic [63:0] code, input logic has_secondary);
    src_supported = (code == {32'h0, SRC_PRIMARY}) || (code == {32'h0, SRC_EXTERNAL})
                    || (has_secondary && (code == {32'h0, SRC_SECONDARY}));
  endfunction

  // Rate grid of a source
  function automatic logic [5:0] src_shift(input logic [31:0] code);
    case (code)
      SRC_SECONDARY: src_shift = SHIFT_SECONDARY;
      SRC_EXTERNAL:  src_shift = SHIFT_EXTERNAL;
      default:       src_shift = SHIFT_PRIMARY;
    endcase
  endfunction

  // Nearest rate on the grid of a source
  function automatic logic [63:0] nearest_rate(input logic [63:0] rate, input logic [5:0] sh);
    logic [63:0] half;
    half = (sh == 6'h00) ? 64'h0 : (64'h1 << (sh - 6'h01));
    nearest_rate = ((rate + half) >> sh) << sh;
  endfunction

endpackage
`default_nettype wire

// [lock_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
module lock_supervisor
  import clock_source_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_MAX_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic arm,
  input  wire logic pll_locked,
  output var  logic lock_ok,
  output var  logic lock_fail
);

  typedef struct packed {
    lock_state_t           st;
    logic [LOCK_CNT_W-1:0] cnt;
    logic                  ok;
    logic                  fail;
  } sup_t;

  sup_t s;
  sup_t next_s;

  // ----------------------------------------------------------------
  // Wait for lock, give up after the longest lock time
  // ----------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.ok   = 1'b0;
    next_s.fail = 1'b0;
    if (arm) begin
      next_s.st  = LK_WAIT;
      next_s.cnt = '0;
    end else begin
      case (s.st)
        LK_IDLE: begin
          next_s.cnt = '0;
        end
        LK_WAIT: begin
          if (pll_locked) begin
            next_s.ok = 1'b1;
            next_s.st = LK_IDLE;
          end else if (s.cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
            next_s.fail = 1'b1;
            next_s.st   = LK_IDLE;
          end else begin
            next_s.cnt = s.cnt + LOCK_CNT_W'(1);
          end
        end
        default: begin
          next_s.st = LK_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lock_ok   = s.ok;
  assign lock_fail = s.fail;

endmodule
`default_nettype wire

// [pll_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Behavioural PLL and sampling clock source
// ----------------------------------------------------------------
module pll_model #(
  parameter int unsigned LOCK_DLY = 5
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        lock_en,
  input  wire logic [1:0]  pll_ref_sel,
  input  wire logic [63:0] pll_mult,
  output var  logic        pll_locked,
  output var  logic        sample_clk_in
);
  logic [1:0]  last_sel;
  logic [63:0] last_mult;
  int          cnt;

  // Lock drops on any setting change and returns after a delay
  always_ff @(posedge clk) begin
    if (srst) begin
      pll_locked    <= 1'b0;
      sample_clk_in <= 1'b0;
      last_sel      <= 2'h0;
      last_mult     <= 64'h0;
      cnt           <= 0;
    end else begin
      sample_clk_in <= ~sample_clk_in;
      last_sel      <= pll_ref_sel;
      last_mult     <= pll_mult;
      if (!lock_en || last_sel != pll_ref_sel || last_mult != pll_mult) begin
        cnt        <= 0;
        pll_locked <= 1'b0;
      end else if (cnt < LOCK_DLY) begin
        cnt <= cnt + 1;
      end else begin
        pll_locked <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [sampling_clock_source_control.sv]
`timescale 1ns/1ps
`default_nettype none
module sampling_clock_source_control
  import clock_source_pkg::*;
#(
  parameter int unsigned LOCK_TIMEOUT_CYCLES = LOCK_MAX_CYCLES,
  parameter logic        HAS_SECONDARY       = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_index,
  input  wire logic [63:0] reg_wdata,
  output var  logic [63:0] reg_rdata,
  output var  logic        reg_ack,
  output var  logic        reg_err,
  input  wire logic        start_req,
  input  wire logic        pll_locked,
  input  wire logic        sample_clk_in,
  output var  logic        clk_out,
  output var  logic        clk_out_oe_n,
  output var  logic [1:0]  pll_ref_sel,
  output var  logic [63:0] pll_mult,
  output var  logic [5:0]  pll_shift,
  output var  logic        sync_distribute,
  output var  logic        clock_ready,
  output var  logic        lock_failure_error
);

  localparam logic [31:0] AVAIL_MASK = SRC_PRIMARY | SRC_EXTERNAL | (HAS_SECONDARY ? SRC_SECONDARY : 32'h0);

  typedef struct packed {
    logic [63:0] rate;
    logic [63:0] ref_hz;
    logic [31:0] mode;
    logic        gate;
    logic        sync_req;
    logic        pending;
    logic        arm;
    logic [63:0] rdata;
    logic        ack;
    logic        err;
    logic        clk_out;
    logic        oe_n;
    logic [1:0]  sel;
    logic [63:0] mult;
    logic [5:0]  shift;
    logic        sync_en;
    logic        ready;
    logic        lock_err;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    rate: RATE_RESET, ref_hz: REF_RESET, mode: SRC_PRIMARY, gate: 1'b0, sync_req: 1'b0,
    pending: 1'b1, arm: 1'b0, rdata: 64'h0, ack: 1'b0, err: 1'b0, clk_out: 1'b0,
    oe_n: 1'b1, sel: SEL_PRIMARY, mult: 64'h0, shift: SHIFT_PRIMARY, sync_en: 1'b0,
    ready: 1'b0, lock_err: 1'b0};

  ctl_t        s;
  ctl_t        next_s;
  logic        lock_ok;
  logic        lock_fail;
  logic [63:0] achieved;

  // ----------------------------------------------------------------
  // Lock supervision
  // ----------------------------------------------------------------
  lock_supervisor #(
    .LOCK_CYCLES (LOCK_TIMEOUT_CYCLES)
  ) lock_supervisor_inst (
    .clk        (clk),
    .srst       (srst),
    .arm        (s.arm),
    .pll_locked (pll_locked),
    .lock_ok    (lock_ok),
    .lock_fail  (lock_fail)
  );

  // Nearest rate the selected source can reach
  assign achieved = nearest_rate(s.rate, src_shift(s.mode));

  // ----------------------------------------------------------------
  // Control and register access
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.ack = 1'b0;
    next_s.err = 1'b0;
    next_s.arm = 1'b0;
    // Lock results
    if (lock_ok) begin
      next_s.ready   = 1'b1;
      next_s.pending = 1'b0;
    end
    // Start request: lock first when settings changed
    if (start_req) begin
      if (s.mode == SRC_EXTERNAL && s.ref_hz == 64'h0) begin
        next_s.lock_err = 1'b1;
      end else if (s.pending) begin
        next_s.lock_err = 1'b0;
        next_s.ready    = 1'b0;
        next_s.arm      = 1'b1;
      end else begin
        next_s.lock_err = 1'b0;
        next_s.ready    = 1'b1;
      end
    end
    if (lock_fail) begin
      next_s.lock_err = 1'b1;
    end
    // Register writes; a read only when there is no write
    if (reg_wr) begin
      next_s.ack = 1'b1;
      case (reg_index)
        IDX_RATE: begin
          next_s.rate    = reg_wdata;
          next_s.pending = 1'b1;
          next_s.ready   = 1'b0;
        end
        IDX_REFCLK: begin
          next_s.ref_hz  = reg_wdata;
          next_s.pending = 1'b1;
          next_s.ready   = 1'b0;
        end
        IDX_MODE: begin
          if (src_supported(reg_wdata, HAS_SECONDARY)) begin
            next_s.mode = reg_wdata[31:0];
            if (reg_wdata[31:0] != s.mode) begin
              next_s.pending = 1'b1;
              next_s.ready   = 1'b0;
            end
          end else begin
            next_s.err = 1'b1;
          end
        end
        IDX_CLKOUT: begin
          next_s.gate = reg_wdata[0];
        end
        IDX_SYNC: begin
          next_s.sync_req = reg_wdata[0];
        end
        default: begin
          next_s.err = 1'b1;
        end
      endcase
    end else if (reg_rd) begin
      next_s.ack = 1'b1;
      case (reg_index)
        IDX_RATE:    next_s.rdata = achieved;
        IDX_REFCLK:  next_s.rdata = s.ref_hz;
        IDX_MODE:    next_s.rdata = {32'h0, s.mode};
        IDX_AVAIL:   next_s.rdata = {32'h0, AVAIL_MASK};
        IDX_CLKOUT:  next_s.rdata = {63'h0, s.gate};
        IDX_OUTFREQ: next_s.rdata = s.gate ? achieved : 64'h0;
        IDX_SYNC:    next_s.rdata = {63'h0, s.sync_req};
        default: begin
          next_s.rdata = 64'h0;
          next_s.err   = 1'b1;
        end
      endcase
    end
    // Clock output gate, same for every source
    next_s.clk_out = s.gate & sample_clk_in;
    next_s.oe_n    = ~s.gate;
    // PLL reference and settings from the selected source
    case (s.mode)
      SRC_SECONDARY: next_s.sel = SEL_SECONDARY;
      SRC_EXTERNAL:  next_s.sel = SEL_EXTERNAL;
      default:       next_s.sel = SEL_PRIMARY;
    endcase
    next_s.shift   = src_shift(s.mode);
    next_s.mult    = achieved >> src_shift(s.mode);
    next_s.sync_en = s.sync_req && (s.mode != SRC_SECONDARY);
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata          = s.rdata;
  assign reg_ack            = s.ack;
  assign reg_err            = s.err;
  assign clk_out            = s.clk_out;
  assign clk_out_oe_n       = s.oe_n;
  assign pll_ref_sel        = s.sel;
  assign pll_mult           = s.mult;
  assign pll_shift          = s.shift;
  assign sync_distribute    = s.sync_en;
  assign clock_ready        = s.ready;
  assign lock_failure_error = s.lock_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_mode_ok_wr;
    reg_wr && reg_index == IDX_MODE && src_supported(reg_wdata, HAS_SECONDARY);
  endsequence
  sequence s_gate_wr(logic v);
    reg_wr && reg_index == IDX_CLKOUT && reg_wdata[0] == v;
  endsequence

  property p_mode_write;
    s_mode_ok_wr ##1 (!reg_wr && !reg_rd) ##1 (reg_rd && !reg_wr && reg_index == IDX_MODE)
      |=> reg_rdata == {32'h0, $past(reg_wdata[31:0], 3)};
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode readback wrong");

  property p_reject;
    reg_wr && reg_index == IDX_MODE && !src_supported(reg_wdata, HAS_SECONDARY) |=> reg_err && $stable(s.mode);
  endproperty
  a_reject: assert property (p_reject) else $error("unsupported source accepted");

  property p_avail;
    reg_rd && !reg_wr && reg_index == IDX_AVAIL |=> reg_ack && reg_rdata == {32'h0, AVAIL_MASK} && reg_rdata[0];
  endproperty
  a_avail: assert property (p_avail) else $error("source mask wrong");

  property p_rate_grid;
    reg_rd && !reg_wr && reg_index == IDX_RATE && s.mode == SRC_EXTERNAL |=> reg_rdata[9:0] == 10'h000;
  endproperty
  a_rate_grid: assert property (p_rate_grid) else $error("rate not on grid");

  property p_gate_on;
    s_gate_wr(1'b1) ##1 !reg_wr[*2] |-> ##1 !clk_out_oe_n;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("output not driven");

  property p_gate_off;
    s_gate_wr(1'b0) |-> ##2 clk_out_oe_n && !clk_out;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("output not floated");

  property p_reset_src;
    $past(srst) |-> s.mode == SRC_PRIMARY && s.pending;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset source not primary");

  property p_ext_pll;
    s.mode == SRC_EXTERNAL |=> pll_ref_sel == SEL_EXTERNAL && pll_shift == SHIFT_EXTERNAL;
  endproperty
  a_ext_pll: assert property (p_ext_pll) else $error("external not through pll");

  property p_wait_lock;
    start_req && s.pending && !(s.mode == SRC_EXTERNAL && s.ref_hz == 64'h0)
      |=> !clock_ready ##1 (!clock_ready || $past(lock_ok));
  endproperty
  a_wait_lock: assert property (p_wait_lock) else $error("ready before lock");

  property p_lock_fail;
    lock_fail |=> lock_failure_error && !clock_ready;
  endproperty
  a_lock_fail: assert property (p_lock_fail) else $error("lock failure not reported");

  property p_sync_src;
    sync_distribute |-> pll_ref_sel != SEL_SECONDARY;
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("sync from secondary");

  property p_outfreq;
    reg_rd && !reg_wr && reg_index == IDX_OUTFREQ && !s.gate |=> reg_rdata == 64'h0;
  endproperty
  a_outfreq: assert property (p_outfreq) else $error("output frequency wrong");

endmodule
`default_nettype wire

// [sampling_clock_source_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sampling_clock_source_control_tb_top
  import clock_source_pkg::*;
;
  logic        clk, srst, reg_wr, reg_rd, start_req, lock_en;
  logic [15:0] reg_index;
  logic [63:0] reg_wdata, reg_rdata, pll_mult, rd;
  logic        reg_ack, reg_err, pll_locked, sample_clk_in, er;
  logic        clk_out, clk_out_oe_n, sync_distribute, clock_ready, lock_failure_error;
  logic [1:0]  pll_ref_sel;
  logic [5:0]  pll_shift;
  int          fails, n_tests, cyc, i;

  // ----------------------------------------------------------------
  // Design and PLL model
  // ----------------------------------------------------------------
  sampling_clock_source_control #(.LOCK_TIMEOUT_CYCLES(20), .HAS_SECONDARY(1'b1))
    sampling_clock_source_control_inst (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .start_req(start_req), .pll_locked(pll_locked), .sample_clk_in(sample_clk_in),
    .clk_out(clk_out), .clk_out_oe_n(clk_out_oe_n), .pll_ref_sel(pll_ref_sel),
    .pll_mult(pll_mult), .pll_shift(pll_shift), .sync_distribute(sync_distribute),
    .clock_ready(clock_ready), .lock_failure_error(lock_failure_error));

  pll_model #(.LOCK_DLY(5)) pll_model_inst (
    .clk(clk), .srst(srst), .lock_en(lock_en), .pll_ref_sel(pll_ref_sel),
    .pll_mult(pll_mult), .pll_locked(pll_locked), .sample_clk_in(sample_clk_in));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register access, answered one cycle after it is taken
  task automatic acc(input logic w, input logic [15:0] idx, input logic [63:0] d);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_index <= idx;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    er = reg_err;
    chk("ack", {63'h0, reg_ack}, 64'h1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [63:0] d, input logic e);
    acc(1'b1, idx, d);
    chk("write err", {63'h0, er}, {63'h0, e});
  endtask

  task automatic rdc(input string what, input logic [15:0] idx, input logic [63:0] e);
    acc(1'b0, idx, 64'h0);
    chk(what, rd, e);
    chk("read err", {63'h0, er}, 64'h0);
  endtask

  // Start the card and wait a bounded time for the clock
  task automatic start_card();
    @(posedge clk);
    start_req <= 1'b1;
    @(posedge clk);
    start_req <= 1'b0;
    #1;
    // Status is looked at only once it has settled after the edge
    for (i = 0; i < 40 && clock_ready !== 1'b1 && lock_failure_error !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Gate the output on, watch it follow, read frequency, gate off
  task automatic gate_check(input logic [63:0] f);
    wr(IDX_CLKOUT, 64'h1, 1'b0);
    @(posedge clk);
    #1;
    chk("oe_n on", {63'h0, clk_out_oe_n}, 64'h0);
    repeat (3) begin
      @(posedge clk);
      #1;
      chk("clk_out", {63'h0, clk_out}, {63'h0, ~sample_clk_in});
    end
    rdc("out freq", IDX_OUTFREQ, f);
    wr(IDX_CLKOUT, 64'h0, 1'b0);
    rdc("out freq off", IDX_OUTFREQ, 64'h0);
    chk("oe_n off", {63'h0, clk_out_oe_n}, 64'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    start_req = 1'b0;
    lock_en = 1'b1;
    reg_index = 16'h0;
    reg_wdata = 64'h0;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;

    // Reset state
    rdc("mode", IDX_MODE, {32'h0, SRC_PRIMARY});
    rdc("mask", IDX_AVAIL, 64'h0000_0000_0000_0025);
    rdc("rate", IDX_RATE, 64'h0000_0000_0098_9680);
    $display("TEST reset done");

    // Primary source: exact rate, output gate, lock
    wr(IDX_RATE, 64'h0000_0000_03B9_ACA0, 1'b0);
    rdc("rate primary", IDX_RATE, 64'h0000_0000_03B9_ACA0);
    chk("mult primary", pll_mult, 64'h0000_0000_03B9_ACA0);
    chk("sel primary", {62'h0, pll_ref_sel}, 64'h0);
    gate_check(64'h0000_0000_03B9_ACA0);
    start_card();
    chk("ready", {63'h0, clock_ready}, 64'h1);
    chk("no error", {63'h0, lock_failure_error}, 64'h0);
    $display("TEST primary done");

    // Secondary source: rate rounded to its grid
    wr(IDX_MODE, {32'h0, SRC_SECONDARY}, 1'b0);
    chk("ready dropped", {63'h0, clock_ready}, 64'h0);
    rdc("mode sec", IDX_MODE, {32'h0, SRC_SECONDARY});
    wr(IDX_RATE, 64'h0000_0000_000F_4247, 1'b0);
    rdc("rate sec", IDX_RATE, 64'h0000_0000_000F_4240);
    chk("sel sec", {62'h0, pll_ref_sel}, 64'h1);
    chk("shift sec", {58'h0, pll_shift}, 64'h4);
    $display("TEST secondary done");

    // External reference through the PLL
    wr(IDX_MODE, {32'h0, SRC_EXTERNAL}, 1'b0);
    wr(IDX_REFCLK, 64'h0000_0000_0098_9680, 1'b0);
    wr(IDX_RATE, 64'h0000_0000_03E2_E080, 1'b0);
    rdc("rate ext", IDX_RATE, 64'h0000_0000_03E2_E000);
    chk("sel ext", {62'h0, pll_ref_sel}, 64'h2);
    chk("shift ext", {58'h0, pll_shift}, 64'h0A);
    gate_check(64'h0000_0000_03E2_E000);
    wr(IDX_SYNC, 64'h1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("sync", {63'h0, sync_distribute}, 64'h1);
    $display("TEST external done");

    // Refused accesses leave state alone
    wr(IDX_MODE, 64'h0000_0000_0000_0002, 1'b1);
    wr(IDX_MODE, 64'h0000_0001_0000_0001, 1'b1);
    rdc("mode kept", IDX_MODE, {32'h0, SRC_EXTERNAL});
    wr(IDX_AVAIL, 64'h0, 1'b1);
    rdc("mask kept", IDX_AVAIL, 64'h0000_0000_0000_0025);
    wr(IDX_OUTFREQ, 64'h5, 1'b1);
    acc(1'b0, 16'h1234, 64'h0);
    chk("unmapped err", {63'h0, er}, 64'h1);
    $display("TEST refusal done");

    // PLL never locks after a change, then relocks once lock is enabled again
    wr(IDX_MODE, {32'h0, SRC_PRIMARY}, 1'b0);
    lock_en <= 1'b0;
    start_card();
    chk("lock fail", {63'h0, lock_failure_error}, 64'h1);
    chk("not ready", {63'h0, clock_ready}, 64'h0);
    lock_en <= 1'b1;
    start_card();
    chk("relock", {63'h0, clock_ready}, 64'h1);
    chk("error cleared", {63'h0, lock_failure_error}, 64'h0);
    // External reference with no frequency programmed cannot lock
    wr(IDX_MODE, {32'h0, SRC_EXTERNAL}, 1'b0);
    wr(IDX_REFCLK, 64'h0, 1'b0);
    start_card();
    chk("no reference", {63'h0, lock_failure_error}, 64'h1);
    chk("no ref not ready", {63'h0, clock_ready}, 64'h0);
    $display("TEST lock done");
    give_verdict();
  end
endmodule
`default_nettype wire
